// ==== design/lp_seq_map.vh ====
`ifndef LP_SEQ_MAP_VH
`define LP_SEQ_MAP_VH

// clock and stabilization timing
`define CLK_PERIOD_NS 100
`define STAB_TIME_NS 1000000
`define STAB_CYCLES_DEF ((`STAB_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STAB_W 16

// register byte offsets
`define ADDR_W 8
`define OFS_CTRL 8'h00
`define OFS_MISC 8'h04
`define OFS_CMD 8'h08
`define OFS_IRQ 8'h0c
`define OFS_STAT 8'h10
`define OFS_DT 8'h20

// field positions
`define CTRL_WTB_BIT 0
`define CTRL_LOW_SPEED_ON_FLAG_BIT 1
`define DT_BIT 3
`define CMD_HALT_BIT 0
`define CMD_SBY_BIT 1
`define IRQ_TA_FLAG_BIT 0
`define IRQ_EXT_FLAG_BIT 1
`define IRQ_GIE_BIT 2
`define IRQ_TA_MASK_BIT 4
`define IRQ_EXT_MASK_BIT 5
`define STAT_BUSY_BIT 4

// reset values
`define MISC_RST 2'h0
`define MASK_RST 1'b1

// timebase: prescaler w and timer a widths, frame taps as counter bit positions (frame of 2^tap sub-clock ticks)
`define PW_W 3
`define TA_W 8
`define TAP0 5
`define TAP1 7
`define TAP2 9

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== design/frame_timebase.v ====
`timescale 1ns/1ps
`include "lp_seq_map.vh"
module frame_timebase #(
    parameter PW_W = `PW_W,
    parameter TA_W = `TA_W
)(
    // clock and reset
    input wire clk,
    input wire nrst,
    // control
    input wire clr,
    input wire tick,
    input wire [1:0] sel,
    // events
    output reg strobe_q,
    output reg ovf_q
);

localparam CW = PW_W + TA_W;

reg [CW-1:0] cnt_q;
reg tap_hit;
wire [CW-1:0] cnt_n = cnt_q + {{(CW-1){1'b0}}, 1'b1};

// code 3 reserved, falls back to the shortest frame
always @*
begin
    case (sel)
        2'h1: tap_hit = (cnt_n[`TAP1-1:0] == {`TAP1{1'b0}});
        2'h2: tap_hit = (cnt_n[`TAP2-1:0] == {`TAP2{1'b0}});
        default: tap_hit = (cnt_n[`TAP0-1:0] == {`TAP0{1'b0}});
    endcase
end

always @(posedge clk or negedge nrst)
begin
    if (!nrst)
    begin
        cnt_q <= {CW{1'b0}};
        strobe_q <= 1'b0;
        ovf_q <= 1'b0;
    end
    else if (clr)
    begin
        cnt_q <= {CW{1'b0}};
        strobe_q <= 1'b0;
        ovf_q <= 1'b0;
    end
    else
    begin
        if (tick)
            cnt_q <= cnt_n;
        strobe_q <= tick & tap_hit;
        // timer a wrap always lands on a frame strobe
        ovf_q <= tick & (cnt_n == {CW{1'b0}});
    end
end

endmodule

// ==== design/low_power_mode_sequencer.v ====
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "lp_seq_map.vh"
module low_power_mode_sequencer #(
    parameter STAB_CYCLES = `STAB_CYCLES_DEF
)(
    // clock and reset
    input wire CLK,
    input wire NRST,
    // external pins
    input wire SUB_CLK,
    input wire WAKE_N,
    // axi4-lite write address
    input wire AWVALID,
    output reg AWREADY,
    input wire [`ADDR_W-1:0] AWADDR,
    input wire [2:0] AWPROT,
    // axi4-lite write data
    input wire WVALID,
    output reg WREADY,
    input wire [31:0] WDATA,
    input wire [3:0] WSTRB,
    // axi4-lite write response
    output reg BVALID,
    input wire BREADY,
    output reg [1:0] BRESP,
    // axi4-lite read address
    input wire ARVALID,
    output reg ARREADY,
    input wire [`ADDR_W-1:0] ARADDR,
    input wire [2:0] ARPROT,
    // axi4-lite read data
    output reg RVALID,
    input wire RREADY,
    output reg [31:0] RDATA,
    output reg [1:0] RRESP,
    // mode outputs
    output reg [2:0] MODE,
    output reg SYS_OSC_EN,
    output reg CPU_RUN,
    output reg CPU_CLK_SUB,
    output reg RAM_RETAIN,
    output reg TIMER_A_IRQ_FLAG,
    output reg EXT_IRQ0_FLAG
);

localparam ST_ACTIVE = 3'h0;
localparam ST_STANDBY = 3'h1;
localparam ST_STOP = 3'h2;
localparam ST_WATCH = 3'h3;
localparam ST_SUBACT = 3'h4;
localparam ST_WAKE = 3'h5;
localparam ST_DT = 3'h6;

// cut on purpose, the count must fit the stabilization counter
localparam integer STAB_M1 = STAB_CYCLES - 1;
localparam [`STAB_W-1:0] STAB_LOAD = STAB_M1[`STAB_W-1:0];

// pin synchronisers, first stage read only by second
reg [1:0] sync1_q;
reg [1:0] sync2_q;
reg sub_prev_q;
reg wake_prev_q;
wire sub_s = sync2_q[0];
wire wake_s = sync2_q[1];
wire sub_tick = sub_s & ~sub_prev_q;

always @(posedge CLK or negedge NRST)
begin
    if (!NRST)
    begin
        sync1_q <= 2'h3;
        sync2_q <= 2'h3;
        sub_prev_q <= 1'b1;
        wake_prev_q <= 1'b1;
    end
    else
    begin
        sync1_q <= {WAKE_N, SUB_CLK};
        sync2_q <= sync1_q;
        sub_prev_q <= sub_s;
        wake_prev_q <= wake_s;
    end
end

// state and software bits
reg [2:0] mode_q;
reg [2:0] mode_d;
reg wtb_sel_q;
reg low_speed_on_flag_q;
reg dt_q;
reg [1:0] frame_sel_q;
reg gie_q;
reg ta_mask_q;
reg ext_mask_q;
reg ta_flag_q;
reg ext_flag_q;
reg wake_samp_q;
reg ext_pend_q;
reg [`STAB_W-1:0] stab_q;

// axi write path, address and data taken in either order
reg aw_have_q;
reg w_have_q;
reg [`ADDR_W-1:0] awaddr_q;
reg [7:0] wbyte_q;
reg wstrb0_q;
wire wr_go = aw_have_q & w_have_q & ~BVALID;
wire wr_en = wr_go & wstrb0_q;

always @(posedge CLK or negedge NRST)
begin
    if (!NRST)
    begin
        AWREADY <= 1'b0;
        WREADY <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        awaddr_q <= {`ADDR_W{1'b0}};
        wbyte_q <= 8'h00;
        wstrb0_q <= 1'b0;
        BVALID <= 1'b0;
        BRESP <= `RESP_OKAY;
    end
    else
    begin
        if (AWVALID && AWREADY)
        begin
            awaddr_q <= AWADDR;
            aw_have_q <= 1'b1;
            AWREADY <= 1'b0;
        end
        else if (!aw_have_q && !BVALID)
            AWREADY <= 1'b1;
        if (WVALID && WREADY)
        begin
            wbyte_q <= WDATA[7:0];
            wstrb0_q <= WSTRB[0];
            w_have_q <= 1'b1;
            WREADY <= 1'b0;
        end
        else if (!w_have_q && !BVALID)
            WREADY <= 1'b1;
        if (wr_go)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            BVALID <= 1'b1;
            case (awaddr_q)
                `OFS_CTRL, `OFS_MISC, `OFS_CMD, `OFS_IRQ, `OFS_STAT, `OFS_DT:
                    BRESP <= `RESP_OKAY;
                default:
                    BRESP <= `RESP_SLVERR;
            endcase
        end
        else if (BVALID && BREADY)
            BVALID <= 1'b0;
    end
end

// instruction strobes from the core
wire cmd_wr = wr_en & (awaddr_q == `OFS_CMD) & CPU_RUN;
wire halt_i = cmd_wr & wbyte_q[`CMD_HALT_BIT];
wire sby_i = cmd_wr & wbyte_q[`CMD_SBY_BIT] & ~wbyte_q[`CMD_HALT_BIT];
wire irq_wr = wr_en & (awaddr_q == `OFS_IRQ);
wire nop_c = ~gie_q & ((ta_flag_q & ~ta_mask_q) | (ext_flag_q & ~ext_mask_q));
wire instr = (halt_i | sby_i) & ~nop_c;

// frame timebase
wire strobe;
wire ovf;
// timebase halted and cleared in stop
wire tb_clr = (mode_q == ST_STOP);

// prescaler w and timer a as frame base
frame_timebase #(
    .PW_W(`PW_W),
    .TA_W(`TA_W)
) u_tb (
    .clk(CLK),
    .nrst(NRST),
    .clr(tb_clr),
    .tick(sub_tick),
    .sel(frame_sel_q),
    .strobe_q(strobe),
    .ovf_q(ovf)
);

wire lp = (mode_q == ST_WATCH) | (mode_q == ST_SUBACT) | (mode_q == ST_DT);
// in subactive, a strobe coinciding with an instruction drops requests
wire drop = (mode_q == ST_SUBACT) & instr & strobe;
wire lp_fall = strobe & wake_samp_q & ~wake_s;
wire ta_req = ovf & ~tb_clr & ~drop;
// low-power wake request only at a strobe
wire ext_req = lp ? (strobe & ext_pend_q & ~drop)
                  : (~tb_clr & wake_prev_q & ~wake_s);

always @(posedge CLK or negedge NRST)
begin
    if (!NRST)
    begin
        wake_samp_q <= 1'b1;
        ext_pend_q <= 1'b0;
        ta_flag_q <= 1'b0;
        ext_flag_q <= 1'b0;
    end
    else
    begin
        if (strobe)
            wake_samp_q <= wake_s;
        if (!lp || drop)
            ext_pend_q <= 1'b0;
        else if (lp_fall)
            ext_pend_q <= 1'b1;
        else if (strobe)
            ext_pend_q <= 1'b0;
        // set wins over a write-one clear
        ta_flag_q <= ta_req | (ta_flag_q & ~(irq_wr & wbyte_q[`IRQ_TA_FLAG_BIT]));
        ext_flag_q <= ext_req | (ext_flag_q & ~(irq_wr & wbyte_q[`IRQ_EXT_FLAG_BIT]));
    end
end

// mode sequencing
always @*
begin
    mode_d = mode_q;
    case (mode_q)
        ST_ACTIVE:
        begin
            // halt with timebase select enters watch
            // halt with select clear enters stop
            if (instr && halt_i)
                mode_d = wtb_sel_q ? ST_WATCH : ST_STOP;
            else if (instr && sby_i)
                mode_d = ST_STANDBY;
        end
        ST_STANDBY:
        begin
            if (ta_req || ext_req)
                mode_d = ST_ACTIVE;
        end
        ST_STOP:
            mode_d = ST_STOP;
        ST_WATCH:
        begin
            if (ta_req || ext_req)
                mode_d = low_speed_on_flag_q ? ST_SUBACT : ST_WAKE;
        end
        ST_SUBACT:
        begin
            if (instr)
                mode_d = (dt_q && !low_speed_on_flag_q) ? ST_DT : ST_WATCH;
        end
        ST_DT:
        begin
            if (strobe)
                mode_d = ST_WAKE;
        end
        ST_WAKE:
        begin
            if (stab_q == {`STAB_W{1'b0}})
                mode_d = ST_ACTIVE;
        end
        default:
            mode_d = ST_ACTIVE;
    endcase
end

always @(posedge CLK or negedge NRST)
begin
    if (!NRST)
    begin
        mode_q <= ST_ACTIVE;
        stab_q <= {`STAB_W{1'b0}};
        MODE <= ST_ACTIVE;
        SYS_OSC_EN <= 1'b1;
        CPU_RUN <= 1'b1;
        CPU_CLK_SUB <= 1'b0;
        RAM_RETAIN <= 1'b0;
        TIMER_A_IRQ_FLAG <= 1'b0;
        EXT_IRQ0_FLAG <= 1'b0;
    end
    else
    begin
        mode_q <= mode_d;
        if (mode_d == ST_WAKE && mode_q != ST_WAKE)
            stab_q <= STAB_LOAD;
        else if (stab_q != {`STAB_W{1'b0}})
            stab_q <= stab_q - {{(`STAB_W-1){1'b0}}, 1'b1};
        MODE <= mode_d;
        SYS_OSC_EN <= (mode_d == ST_ACTIVE) | (mode_d == ST_STANDBY) | (mode_d == ST_WAKE);
        CPU_RUN <= (mode_d == ST_ACTIVE) | (mode_d == ST_SUBACT);
        // subactive cpu on the sub clock
        CPU_CLK_SUB <= (mode_d == ST_SUBACT);
        // ram kept, no clear leaves stop
        RAM_RETAIN <= (mode_d != ST_ACTIVE) & (mode_d != ST_SUBACT);
        TIMER_A_IRQ_FLAG <= ta_req | (ta_flag_q & ~(irq_wr & wbyte_q[`IRQ_TA_FLAG_BIT]));
        EXT_IRQ0_FLAG <= ext_req | (ext_flag_q & ~(irq_wr & wbyte_q[`IRQ_EXT_FLAG_BIT]));
    end
end

// software registers
always @(posedge CLK or negedge NRST)
begin
    if (!NRST)
    begin
        wtb_sel_q <= 1'b0;
        low_speed_on_flag_q <= 1'b0;
        dt_q <= 1'b0;
        frame_sel_q <= `MISC_RST;
        gie_q <= 1'b0;
        ta_mask_q <= `MASK_RST;
        ext_mask_q <= `MASK_RST;
    end
    else
    begin
        if (wr_en && awaddr_q == `OFS_CTRL)
        begin
            wtb_sel_q <= wbyte_q[`CTRL_WTB_BIT];
            low_speed_on_flag_q <= wbyte_q[`CTRL_LOW_SPEED_ON_FLAG_BIT];
        end
        if (wr_en && awaddr_q == `OFS_MISC)
            frame_sel_q <= wbyte_q[1:0];
        if (irq_wr)
        begin
            gie_q <= wbyte_q[`IRQ_GIE_BIT];
            ta_mask_q <= wbyte_q[`IRQ_TA_MASK_BIT];
            ext_mask_q <= wbyte_q[`IRQ_EXT_MASK_BIT];
        end
        if (mode_d == ST_ACTIVE)
            dt_q <= 1'b0;
        else if (wr_en && awaddr_q == `OFS_DT && mode_q == ST_SUBACT)
            dt_q <= wbyte_q[`DT_BIT];
    end
end

// axi read path
reg [7:0] rd_byte;
reg rd_ok;

always @*
begin
    rd_byte = 8'h00;
    rd_ok = 1'b1;
    case (ARADDR)
        `OFS_CTRL:
            rd_byte = {6'h00, low_speed_on_flag_q, wtb_sel_q};
        `OFS_MISC:
            rd_byte = {6'h00, frame_sel_q};
        `OFS_CMD:
            rd_byte = 8'h00;
        `OFS_IRQ:
            rd_byte = {2'h0, ext_mask_q, ta_mask_q, 1'b0, gie_q, ext_flag_q, ta_flag_q};
        `OFS_STAT:
            rd_byte = {3'h0, (mode_q == ST_WAKE), 1'b0, mode_q};
        `OFS_DT:
            rd_byte = {4'h0, dt_q & (mode_q != ST_ACTIVE), 3'h0};
        default:
            rd_ok = 1'b0;
    endcase
end

always @(posedge CLK or negedge NRST)
begin
    if (!NRST)
    begin
        ARREADY <= 1'b0;
        RVALID <= 1'b0;
        RDATA <= 32'h00000000;
        RRESP <= `RESP_OKAY;
    end
    else
    begin
        if (ARVALID && ARREADY)
        begin
            ARREADY <= 1'b0;
            RVALID <= 1'b1;
            RDATA <= {24'h000000, rd_byte};
            RRESP <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (RVALID && RREADY)
            RVALID <= 1'b0;
        else if (!RVALID)
            ARREADY <= 1'b1;
    end
end

endmodule

// ==== dv/lp_seq_sva.sv ====
`timescale 1ns/1ps
module lp_seq_sva #(
    parameter STAB_CYCLES = 5
)(
    // clock and reset
    input wire CLK,
    input wire NRST,
    // mode outputs
    input wire [2:0] MODE,
    input wire SYS_OSC_EN,
    input wire CPU_RUN,
    input wire CPU_CLK_SUB,
    input wire RAM_RETAIN,
    input wire TIMER_A_IRQ_FLAG,
    input wire EXT_IRQ0_FLAG
);
    reg [15:0] wake_cnt_q;
    wire [15:0] wake_cnt_d;
    // cycles spent stabilizing, zero elsewhere
    assign wake_cnt_d = (MODE == 3'h5) ? wake_cnt_q + 16'h1 : 16'h0;
    always @(posedge CLK or negedge NRST)
        if (!NRST)
            wake_cnt_q <= 16'h0;
        else
            wake_cnt_q <= wake_cnt_d;
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    property p_stop_hold;
        MODE == 3'h2 |=> MODE == 3'h2;
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stop left");
    property p_stop_out;
        MODE == 3'h2 |-> !SYS_OSC_EN && !CPU_RUN && !CPU_CLK_SUB;
    endproperty
    a_stop_out: assert property (p_stop_out) else $error("stop outputs");
    property p_ram_keep;
        !CPU_RUN |-> RAM_RETAIN;
    endproperty
    a_ram_keep: assert property (p_ram_keep) else $error("ram not kept");
    property p_sub_clk;
        MODE == 3'h4 |-> CPU_CLK_SUB && CPU_RUN && !SYS_OSC_EN;
    endproperty
    a_sub_clk: assert property (p_sub_clk) else $error("sub clock");
    property p_watch_exit;
        MODE == 3'h3 |=> MODE == 3'h3 || MODE == 3'h4 || MODE == 3'h5;
    endproperty
    a_watch_exit: assert property (p_watch_exit) else $error("watch exit");
    property p_watch_cause;
        MODE == 3'h3 ##1 MODE != 3'h3 |-> ##[0:1] (TIMER_A_IRQ_FLAG || EXT_IRQ0_FLAG);
    endproperty
    a_watch_cause: assert property (p_watch_cause) else $error("watch no flag");
    property p_wake_len;
        MODE == 3'h5 ##1 MODE != 3'h5 |->
            wake_cnt_q >= STAB_CYCLES - 1 && wake_cnt_q <= STAB_CYCLES + 1;
    endproperty
    a_wake_len: assert property (p_wake_len) else $error("stab length");
    property p_direct;
        MODE == 3'h6 |=> MODE == 3'h6 || MODE == 3'h5;
    endproperty
    a_direct: assert property (p_direct) else $error("direct path");
    // second edge, so a missed time-zero event cannot fire it
    property p_reset_state;
        disable iff (1'b0) !NRST ##1 !NRST |-> MODE == 3'h0 && CPU_RUN && SYS_OSC_EN;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state");
    c_stop: cover property (MODE == 3'h2);
    c_sub: cover property (MODE == 3'h3 ##1 MODE == 3'h4);
    c_direct: cover property (MODE == 3'h6 ##1 MODE == 3'h5);
    c_standby: cover property (MODE == 3'h1 ##1 MODE == 3'h0);
endmodule
bind low_power_mode_sequencer lp_seq_sva #(.STAB_CYCLES(STAB_CYCLES)) chk (
    .CLK(CLK), .NRST(NRST), .MODE(MODE), .SYS_OSC_EN(SYS_OSC_EN), .CPU_RUN(CPU_RUN),
    .CPU_CLK_SUB(CPU_CLK_SUB), .RAM_RETAIN(RAM_RETAIN),
    .TIMER_A_IRQ_FLAG(TIMER_A_IRQ_FLAG), .EXT_IRQ0_FLAG(EXT_IRQ0_FLAG));

// ==== dv/far_side.sv ====
`timescale 1ns/1ps
module far_side #(
    parameter HOLD = 400
)(
    // clock
    input wire clk,
    // request
    input wire wake_req,
    // pins
    output reg sub_clk,
    output reg wake_n
);
    // free running, sped up to 1 us so frames stay short
    initial
    begin
        sub_clk = 1'b0;
        forever #500 sub_clk = ~sub_clk;
    end
    initial
    begin
        wake_n = 1'b1;
        forever
        begin
            @(posedge clk);
            if (wake_req)
            begin
                wake_n <= 1'b0;
                repeat (HOLD) @(posedge clk);
                wake_n <= 1'b1;
                repeat (HOLD) @(posedge clk);
            end
        end
    end
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`include "lp_seq_map.vh"
module testbench;
    localparam STAB = 5;
    localparam HOLD = 400;
    // frame select 0: 32 sub ticks of 10 cycles
    localparam T = 320;
    reg CLK, NRST, AWVALID, WVALID, BREADY, ARVALID, RREADY, wake_req;
    reg [7:0] AWADDR, ARADDR;
    reg [31:0] WDATA;
    wire SUB_CLK, WAKE_N, AWREADY, WREADY, BVALID, ARREADY, RVALID, CPU_CLK_SUB;
    wire TIMER_A_IRQ_FLAG, EXT_IRQ0_FLAG;
    wire SYS_OSC_EN, CPU_RUN, RAM_RETAIN;
    wire [1:0] BRESP, RRESP;
    wire [31:0] RDATA;
    wire [2:0] MODE;
    integer error_cnt, n_compared, n, i, dn;
    low_power_mode_sequencer #(.STAB_CYCLES(STAB)) uut (
        .CLK(CLK), .NRST(NRST), .SUB_CLK(SUB_CLK), .WAKE_N(WAKE_N),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR), .AWPROT(3'h0),
        .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(4'hf),
        .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR), .ARPROT(3'h0),
        .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
        .MODE(MODE), .SYS_OSC_EN(SYS_OSC_EN), .CPU_RUN(CPU_RUN), .CPU_CLK_SUB(CPU_CLK_SUB),
        .RAM_RETAIN(RAM_RETAIN), .TIMER_A_IRQ_FLAG(TIMER_A_IRQ_FLAG),
        .EXT_IRQ0_FLAG(EXT_IRQ0_FLAG));
    far_side #(.HOLD(HOLD)) fs (.clk(CLK), .wake_req(wake_req), .sub_clk(SUB_CLK),
        .wake_n(WAKE_N));
    task give_verdict;
        begin
            $display("compared %0d mismatches %0d", n_compared, error_cnt);
            if (error_cnt == 0 && n_compared > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    task chk(input [31:0] g, input [31:0] e);
        begin
            n_compared = n_compared + 1;
            if (g !== e)
            begin
                error_cnt = error_cnt + 1;
                $display("Error at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task chk_rng(input integer g, input integer lo, input integer hi);
        begin
            n_compared = n_compared + 1;
            if (g < lo || g > hi)
            begin
                error_cnt = error_cnt + 1;
                $display("Error at %0t: %h outside %h to %h", $time, g, lo, hi);
            end
        end
    endtask
    // every wait is bounded here
    task tick;
        begin
            n = n + 1;
            if (n > 30000)
            begin
                error_cnt = error_cnt + 1;
                $display("Error at %0t: waited %h of %h", $time, n, 30000);
                give_verdict;
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d, input [1:0] er);
        begin
            @(posedge CLK);
            AWADDR <= a;
            WDATA <= d;
            AWVALID <= 1'b1;
            WVALID <= 1'b1;
            BREADY <= 1'b1;
            n = 0;
            dn = 0;
            while (dn == 0)
            begin
                @(posedge CLK);
                tick;
                if (AWREADY)
                    AWVALID <= 1'b0;
                if (WREADY)
                    WVALID <= 1'b0;
                if (BVALID)
                begin
                    BREADY <= 1'b0;
                    dn = 1;
                    chk({30'h0, BRESP}, {30'h0, er});
                end
            end
        end
    endtask
    task rdc(input [7:0] a, input [31:0] e, input [1:0] er);
        begin
            @(posedge CLK);
            ARADDR <= a;
            ARVALID <= 1'b1;
            RREADY <= 1'b1;
            n = 0;
            dn = 0;
            while (dn == 0)
            begin
                @(posedge CLK);
                tick;
                if (ARREADY)
                    ARVALID <= 1'b0;
                if (RVALID)
                begin
                    RREADY <= 1'b0;
                    dn = 1;
                    chk(RDATA, e);
                    chk({30'h0, RRESP}, {30'h0, er});
                end
            end
        end
    endtask
    task wait_mode(input [2:0] m);
        begin
            n = 0;
            while (MODE !== m)
            begin
                @(negedge CLK);
                tick;
            end
        end
    endtask
    // idle first so the pin has settled high for over a frame
    task wake;
        begin
            repeat (2 * HOLD + 2) @(posedge CLK);
            wake_req <= 1'b1;
            @(posedge CLK);
            wake_req <= 1'b0;
        end
    endtask
    initial
    begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end
    initial
    begin
        NRST = 1'b0;
        {AWVALID, WVALID, BREADY, ARVALID, RREADY, wake_req} = 6'h0;
        AWADDR = 8'h0;
        ARADDR = 8'h0;
        WDATA = 32'h0;
        error_cnt = 0;
        n_compared = 0;
        repeat (20) @(posedge CLK);
        NRST <= 1'b1;
        rdc(`OFS_CTRL, 32'h0, `RESP_OKAY);
        rdc(`OFS_IRQ, 32'h30, `RESP_OKAY);
        rdc(8'h14, 32'h0, `RESP_SLVERR);
        wr(8'h14, 32'hff, `RESP_SLVERR);
        for (i = 2; i >= 0; i = i - 1)
        begin
            wr(`OFS_MISC, i, `RESP_OKAY);
            rdc(`OFS_MISC, i, `RESP_OKAY);
        end
        wr(`OFS_DT, 32'h8, `RESP_OKAY);
        rdc(`OFS_DT, 32'h0, `RESP_OKAY);
        $display("test registers done");
        wr(`OFS_IRQ, 32'h4, `RESP_OKAY);
        wr(`OFS_CMD, 32'h1, `RESP_OKAY);
        rdc(`OFS_STAT, 32'h2, `RESP_OKAY);
        wake;
        repeat (2 * T + 40) @(posedge CLK);
        chk({29'h0, MODE}, 32'h2);
        chk({31'h0, SYS_OSC_EN}, 32'h0);
        chk({31'h0, RAM_RETAIN}, 32'h1);
        NRST <= 1'b0;
        repeat (20) @(posedge CLK);
        chk({29'h0, MODE}, 32'h0);
        NRST <= 1'b1;
        $display("test stop done");
        wr(`OFS_IRQ, 32'h14, `RESP_OKAY);
        wr(`OFS_CTRL, 32'h1, `RESP_OKAY);
        wr(`OFS_CMD, 32'h1, `RESP_OKAY);
        rdc(`OFS_STAT, 32'h3, `RESP_OKAY);
        wake;
        wait_mode(3'h0);
        chk_rng(n, T + STAB, 2 * T + STAB + 12);
        chk({31'h0, EXT_IRQ0_FLAG}, 32'h1);
        $display("test watch wake done");
        wr(`OFS_IRQ, 32'h3, `RESP_OKAY);
        wake;
        repeat (10) @(posedge CLK);
        chk({31'h0, EXT_IRQ0_FLAG}, 32'h1);
        wr(`OFS_CMD, 32'h1, `RESP_OKAY);
        rdc(`OFS_STAT, 32'h0, `RESP_OKAY);
        $display("test nop done");
        wr(`OFS_IRQ, 32'h7, `RESP_OKAY);
        wr(`OFS_CMD, 32'h2, `RESP_OKAY);
        rdc(`OFS_STAT, 32'h1, `RESP_OKAY);
        chk({31'h0, CPU_RUN}, 32'h0);
        wake;
        wait_mode(3'h0);
        chk({31'h0, EXT_IRQ0_FLAG}, 32'h1);
        $display("test standby done");
        wr(`OFS_IRQ, 32'h7, `RESP_OKAY);
        wr(`OFS_CTRL, 32'h3, `RESP_OKAY);
        wr(`OFS_CMD, 32'h1, `RESP_OKAY);
        wake;
        wait_mode(3'h4);
        chk({31'h0, CPU_CLK_SUB}, 32'h1);
        wr(`OFS_IRQ, 32'h7, `RESP_OKAY);
        wr(`OFS_CMD, 32'h2, `RESP_OKAY);
        rdc(`OFS_STAT, 32'h3, `RESP_OKAY);
        wake;
        wait_mode(3'h4);
        wr(`OFS_DT, 32'h8, `RESP_OKAY);
        rdc(`OFS_DT, 32'h8, `RESP_OKAY);
        wr(`OFS_CTRL, 32'h1, `RESP_OKAY);
        wr(`OFS_IRQ, 32'h7, `RESP_OKAY);
        wr(`OFS_CMD, 32'h2, `RESP_OKAY);
        wait_mode(3'h0);
        chk_rng(n, STAB + 1, T + STAB + 12);
        rdc(`OFS_DT, 32'h0, `RESP_OKAY);
        $display("test subactive done");
        wr(`OFS_IRQ, 32'h27, `RESP_OKAY);
        wr(`OFS_CMD, 32'h1, `RESP_OKAY);
        wait_mode(3'h3);
        wait_mode(3'h0);
        chk({31'h0, TIMER_A_IRQ_FLAG}, 32'h1);
        $display("test timer wake done");
        give_verdict;
    end
endmodule
